// File: core/eie_pkg.sv
package xie_pkg;

  // ---------------------------------------------------------------------------
  // register byte addresses on the bus
  // ---------------------------------------------------------------------------
  localparam logic [31:0] ADDR_ENABLE  = 32'h0000_00e8; // interrupt_enable_ext
  localparam logic [31:0] ADDR_PENDING = 32'h0000_00ec; // raw source flags, read only
  localparam logic [31:0] ADDR_STATUS  = 32'h0000_00f0; // sticky events, write one to clear
  localparam logic [31:0] ADDR_MASK    = 32'h0000_00f4; // mask onto the irq output

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ENABLE_RESET = 8'h00; // all sources blocked
  localparam logic [7:0] STATUS_RESET = 8'h00; // no events recorded
  localparam logic [7:0] MASK_RESET   = 8'h00; // irq output quiet

  // ---------------------------------------------------------------------------
  // field layout, shared by enable, pending, status and mask
  // ---------------------------------------------------------------------------
  localparam int unsigned BIT_CAPTURE  = 7; // input capture
  localparam int unsigned BIT_BROWNOUT = 6; // brownout detector
  localparam int unsigned BIT_WATCHDOG = 4; // watchdog time-out
  localparam int unsigned BIT_KEYPAD   = 1; // keypad
  localparam int unsigned BIT_I2C      = 0; // i2c
  localparam logic [7:0]  VALID_BITS   = 8'hd3; // bits 5, 3 and 2 are reserved
  localparam int unsigned REG_WIDTH    = 8; // byte-wide registers

  // ---------------------------------------------------------------------------
  // bus encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2; // only htrans[1] is decoded
  localparam logic        HRESP_OKAY    = 1'h0; // the only answer given

endpackage

// File: core/eie_gate_if.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// carries source flags and enables to the gate, requests and events back
// ---------------------------------------------------------------------------
interface xie_gate_if;
  logic [7:0] pend;        // peripheral pending flags, by bit position
  logic [7:0] en;          // enable register contents
  logic [7:0] req;         // gated requests toward the core
  logic [7:0] evt;         // one-cycle pulse on each request's rise

  modport gate (
    input  pend,
    input  en,
    output req,
    output evt
  );

  modport ctrl (
    output pend,
    output en,
    input  req,
    input  evt
  );
endinterface

// File: core/eie_gate.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// per-bit gating of source flags and rise detection of each request
// ---------------------------------------------------------------------------
module xie_gate (
  input  wire logic   hclk,
  input  wire logic   hresetn,
  xie_gate_if.gate    gif
);

  logic [7:0] req_q;        // request seen last cycle
  logic [7:0] req_d;        // request this cycle

  // ---------------------------------------------------------------------------
  // one gate per bit position
  // ---------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < xie_pkg::REG_WIDTH; i = i + 1) begin : g_bit
      // flag and enable, reserved slots forced off
      assign req_d[i]   = gif.pend[i] & gif.en[i] & xie_pkg::VALID_BITS[i];
      // rise of the request marks one event
      assign gif.evt[i] = req_d[i] & ~req_q[i];
    end
  endgenerate

  assign gif.req = req_d;

  // history of the requests
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= 8'h00;
    end else begin
      req_q <= req_d;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  reserved_quiet_a : assert property (
    @(posedge hclk) disable iff (!hresetn)
    (gif.req & ~xie_pkg::VALID_BITS) == 8'h00 && (gif.evt & ~xie_pkg::VALID_BITS) == 8'h00)
    else $error("reserved slot raised a request");

  event_rise_a : assert property (
    @(posedge hclk) disable iff (!hresetn)
    |gif.evt |=> |(gif.evt ^ 8'hff) && ((req_q & $past(gif.evt)) == $past(gif.evt)))
    else $error("event pulse without a held request");

endmodule

// File: core/eie_top.sv
`timescale 1ns/1ps

module xie_top (
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hresp,
  hrdata,
  capture_pend,
  brownout_pend,
  watchdog_timeout,
  keypad_pend,
  i2c_pend,
  capture_irq_req,
  brownout_irq_req,
  watchdog_irq_req,
  keypad_irq_req,
  i2c_irq_req,
  irq
);

  // ---------------------------------------------------------------------------
  // ports
  // ---------------------------------------------------------------------------
  input  wire logic        hclk;             // bus and core clock
  input  wire logic        hresetn;          // async reset, low active
  input  wire logic        hsel;             // slave select
  input  wire logic [31:0] haddr;            // byte address
  input  wire logic [1:0]  htrans;           // transfer type
  input  wire logic        hwrite;           // write when high
  input  wire logic [2:0]  hsize;            // word only, not decoded
  input  wire logic [31:0] hwdata;           // write data
  input  wire logic        hready;           // bus ready
  output wire logic        hreadyout;        // never stalls
  output wire logic        hresp;            // always okay
  output wire logic [31:0] hrdata;           // read data, registered
  input  wire logic        capture_pend;     // capture peripheral flag
  input  wire logic        brownout_pend;    // brownout detector flag
  input  wire logic        watchdog_timeout; // watchdog time-out flag
  input  wire logic        keypad_pend;      // keypad flag
  input  wire logic        i2c_pend;         // i2c flag
  output wire logic        capture_irq_req;  // gated request to core
  output wire logic        brownout_irq_req; // gated request to core
  output wire logic        watchdog_irq_req; // gated request to core
  output wire logic        keypad_irq_req;   // gated request to core
  output wire logic        i2c_irq_req;      // gated request to core
  output wire logic        irq;              // summary interrupt level

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic        wr_q;        // data phase of a write pending
  logic        wr_d;
  logic [31:0] addr_q;      // address held for the data phase
  logic [31:0] addr_d;
  logic [7:0]  en_q;        // interrupt_enable_ext
  logic [7:0]  en_d;
  logic [7:0]  status_q;    // sticky event bits
  logic [7:0]  status_d;
  logic [7:0]  mask_q;      // irq mask
  logic [7:0]  mask_d;
  logic [31:0] rdata_q;     // read data register
  logic [31:0] rdata_d;

  // ---------------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------------
  logic        addr_ph;     // address phase taken this cycle
  logic        wr_en;       // write to enable register
  logic        wr_status;   // write to status register
  logic        wr_mask;     // write to mask register
  logic [7:0]  wbyte;       // low byte of write data
  logic [7:0]  pend8;       // sources spread to their bit positions

  xie_gate_if gif ();       // link to the gate

  // a transfer is taken on the edge where hsel, hready and a nonseq/seq are seen
  assign addr_ph   = hsel && hready && htrans[1] == xie_pkg::HTRANS_NONSEQ[1];
  assign wbyte     = hwdata[7:0];
  assign wr_en     = wr_q && addr_q == xie_pkg::ADDR_ENABLE;
  assign wr_status = wr_q && addr_q == xie_pkg::ADDR_STATUS;
  assign wr_mask   = wr_q && addr_q == xie_pkg::ADDR_MASK;

  // ---------------------------------------------------------------------------
  // source flags placed at their enable positions
  // ---------------------------------------------------------------------------
  always_comb begin
    pend8                             = 8'h00;
    pend8[xie_pkg::BIT_CAPTURE]       = capture_pend;
    pend8[xie_pkg::BIT_BROWNOUT]      = brownout_pend;
    pend8[xie_pkg::BIT_WATCHDOG]      = watchdog_timeout;
    pend8[xie_pkg::BIT_KEYPAD]        = keypad_pend;
    pend8[xie_pkg::BIT_I2C]           = i2c_pend;
  end

  assign gif.pend = pend8;
  assign gif.en   = en_q;

  // per-bit gating and event detection
  xie_gate xie_gate_i (
    .hclk    (hclk),
    .hresetn (hresetn),
    .gif     (gif.gate)
  );

  // ---------------------------------------------------------------------------
  // requests toward the core
  // ---------------------------------------------------------------------------
  assign capture_irq_req  = gif.req[xie_pkg::BIT_CAPTURE];
  assign brownout_irq_req = gif.req[xie_pkg::BIT_BROWNOUT];
  assign watchdog_irq_req = gif.req[xie_pkg::BIT_WATCHDOG];
  assign keypad_irq_req   = gif.req[xie_pkg::BIT_KEYPAD];
  assign i2c_irq_req      = gif.req[xie_pkg::BIT_I2C];

  // summary interrupt, high while any unmasked event is recorded
  assign irq = |(status_q & mask_q);

  // ---------------------------------------------------------------------------
  // bus phase tracking
  // ---------------------------------------------------------------------------
  // next-value logic of the address capture
  always_comb begin
    wr_d   = 1'b0;
    addr_d = addr_q;
    if (addr_ph) begin
      // hold the address for the data phase
      wr_d   = hwrite;
      addr_d = haddr;
    end
  end

  // registers of the address capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q   <= 1'b0;
      addr_q <= 32'h0000_0000;
    end else begin
      wr_q   <= wr_d;
      addr_q <= addr_d;
    end
  end

  // ---------------------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------------------
  // next-value logic of enable, status and mask
  always_comb begin
    en_d     = en_q;
    mask_d   = mask_q;
    status_d = status_q;
    if (wr_en) begin
      // reserved positions stay zero
      en_d = wbyte & xie_pkg::VALID_BITS;
    end
    if (wr_mask) begin
      mask_d = wbyte & xie_pkg::VALID_BITS;
    end
    if (wr_status) begin
      // write one clears the bit
      status_d = status_q & ~wbyte;
    end
    // a new event wins over a clear in the same cycle
    status_d = status_d | gif.evt;
  end

  // registers of enable, status and mask
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q     <= xie_pkg::ENABLE_RESET;
      mask_q   <= xie_pkg::MASK_RESET;
      status_q <= xie_pkg::STATUS_RESET;
    end else begin
      en_q     <= en_d;
      mask_q   <= mask_d;
      status_q <= status_d;
    end
  end

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  // next-value logic of the read data; uses next values so a read right
  // after a write returns the freshly written byte
  always_comb begin
    rdata_d = rdata_q;
    if (addr_ph && !hwrite) begin
      case (haddr)
        xie_pkg::ADDR_ENABLE: begin
          rdata_d = {24'h00_0000, en_d};
        end
        xie_pkg::ADDR_PENDING: begin
          rdata_d = {24'h00_0000, pend8};
        end
        xie_pkg::ADDR_STATUS: begin
          rdata_d = {24'h00_0000, status_d};
        end
        xie_pkg::ADDR_MASK: begin
          rdata_d = {24'h00_0000, mask_d};
        end
        default: begin
          // unmapped reads as zero
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // register of the read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // bus answers: zero wait, always okay
  assign hreadyout = 1'b1;
  assign hresp     = xie_pkg::HRESP_OKAY;
  assign hrdata    = rdata_q;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  // clearing bit 7 by a write silences capture from the next cycle
  cap_block_a : assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_en && !wbyte[7] |=> !capture_irq_req)
    else $error("capture request passed while disabled");

  // capture request is high while its flag is high and bit 7 is set
  cap_pass_a : assert property (
    @(posedge hclk) disable iff (!hresetn)
    en_q[7] && capture_pend |-> capture_irq_req)
    else $error("capture request lost while enabled");

  // setting bit 6 lets a held brownout flag through one cycle later
  bo_pass_a : assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_en && wbyte[6]) ##1 brownout_pend |-> brownout_irq_req)
    else $error("brownout request not passed after enable");

  // watchdog request appears with its enable when timeout is held
  wdt_enable_a : assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(en_q[4]) && watchdog_timeout |-> watchdog_irq_req ##1 status_q[4])
    else $error("watchdog request missing after enable");

  // keypad requests stay low while bit 1 is clear
  kpd_block_a : assert property (
    @(posedge hclk) disable iff (!hresetn)
    !en_q[1] |-> !keypad_irq_req)
    else $error("keypad request passed while disabled");

  // i2c request equals its flag in the second of two cycles with bit 0 set
  i2c_pass_a : assert property (
    @(posedge hclk) disable iff (!hresetn)
    en_q[0] && i2c_pend ##1 en_q[0] |-> i2c_irq_req == i2c_pend)
    else $error("i2c request wrong while enabled");

  // a recorded watchdog event needs an enabled timeout one cycle before
  wdt_event_a : assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(status_q[4]) |-> $past(watchdog_timeout) && $past(en_q[4]))
    else $error("watchdog event without enable");

  // reserved bits of enable never set
  reserved_en_a : assert property (
    @(posedge hclk) disable iff (!hresetn)
    (en_q & ~xie_pkg::VALID_BITS) == 8'h00)
    else $error("reserved enable bit set");

  // write one clears status bit 0 when no i2c event arrives
  w1c_clear_a : assert property (
    @(posedge hclk) disable iff (!hresetn)
    wr_status && wbyte[0] && !gif.evt[0] |=> !status_q[0])
    else $error("status bit not cleared by write");

endmodule

// File: tb/eie_core_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// core side: notes every request it has seen until told to forget
// ---------------------------------------------------------------------------
module xie_core_model (
  hclk,
  hresetn,
  req,
  clr,
  seen
);
  input  wire logic       hclk;    // core clock
  input  wire logic       hresetn; // async reset, low active
  input  wire logic [7:0] req;     // gated requests by bit position
  input  wire logic       clr;     // forget what was seen
  output logic      [7:0] seen;    // sticky record of taken requests

  // requests are sampled at each rising edge, as the core would
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen <= 8'h00;
    end else if (clr) begin
      seen <= 8'h00;
    end else begin
      seen <= seen | req;
    end
  end
endmodule

// File: tb/eie_top_test.sv
`timescale 1ns/1ps

module xie_top_test;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  logic        hclk;    // 10 mhz clock
  logic        hresetn; // low active reset
  logic        hsel;    // slave select
  logic [31:0] haddr;   // byte address
  logic [1:0]  htrans;  // transfer type
  logic        hwrite;  // direction
  logic [31:0] hwdata;  // write data
  wire         hready;  // one slave: its own ready
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  logic [4:0]  src;     // capture, brownout, watchdog, keypad, i2c flags
  wire  [7:0]  req_v;   // requests in register layout
  wire         cap_r, bro_r, wdt_r, key_r, i2c_r, irq;
  logic        clr;     // partner forget strobe
  wire  [7:0]  seen;    // partner record
  logic [31:0] rd;      // last read data
  int          err_count;
  int          compares;
  int          bits[5] = '{7, 6, 4, 1, 0};

  assign hready = hreadyout;
  assign req_v  = {cap_r, bro_r, 1'b0, wdt_r, 2'b00, key_r, i2c_r};

  xie_top xie_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .capture_pend(src[4]),
    .brownout_pend(src[3]), .watchdog_timeout(src[2]), .keypad_pend(src[1]),
    .i2c_pend(src[0]), .capture_irq_req(cap_r), .brownout_irq_req(bro_r),
    .watchdog_irq_req(wdt_r), .keypad_irq_req(key_r), .i2c_irq_req(i2c_r), .irq(irq));

  xie_core_model xie_core_model_i (.hclk(hclk), .hresetn(hresetn), .req(req_v),
    .clr(clr), .seen(seen));

  // ---------------------------------------------------------------------------
  // clock
  // ---------------------------------------------------------------------------
  always #50 hclk = ~hclk;

  // ---------------------------------------------------------------------------
  // reporting
  // ---------------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // compare any value, four-state exact
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // waits edge by edge for hready, bounded at 20 edges
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      err_count++;
      end_sim();
    end
  endtask

  // one single word transfer; read data taken at the data-phase edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= xie_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk("hresp", {31'h0, xie_pkg::HRESP_OKAY}, {31'h0, hresp});
  endtask

  // read and compare
  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    chk(what, exp, rd);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    src = 5'h00;
    clr = 1'b0;
    err_count = 0;
    compares = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values of the registers
    rchk("enable", xie_pkg::ADDR_ENABLE, {24'h0, xie_pkg::ENABLE_RESET});
    rchk("status", xie_pkg::ADDR_STATUS, {24'h0, xie_pkg::STATUS_RESET});
    rchk("mask", xie_pkg::ADDR_MASK, {24'h0, xie_pkg::MASK_RESET});
    // all sources raised, none enabled
    src <= 5'h1f;
    @(posedge hclk);
    chk("req none", 32'h0, {24'h0, req_v});
    rchk("pending", xie_pkg::ADDR_PENDING, 32'hd3);
    // each enable bit alone passes only its own source
    foreach (bits[i]) begin
      bus(xie_pkg::ADDR_ENABLE, 1'b1, 32'h1 << bits[i]);
      @(posedge hclk);
      chk("req one", 32'h1 << bits[i], {24'h0, req_v});
    end
    // reserved positions neither store nor request
    bus(xie_pkg::ADDR_ENABLE, 1'b1, 32'hff);
    rchk("enable rsv", xie_pkg::ADDR_ENABLE, {24'h0, xie_pkg::VALID_BITS});
    chk("req all", {24'h0, xie_pkg::VALID_BITS}, {24'h0, req_v});
    bus(xie_pkg::ADDR_ENABLE, 1'b1, 32'h0);
    @(posedge hclk);
    chk("req off", 32'h0, {24'h0, req_v});
    // each rise recorded; write one clears
    rchk("status ev", xie_pkg::ADDR_STATUS, 32'hd3);
    bus(xie_pkg::ADDR_STATUS, 1'b1, 32'hff);
    rchk("status clr", xie_pkg::ADDR_STATUS, 32'h0);
    // watchdog time-out with the enable off stays silent
    src <= 5'h04;
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    chk("wdt off", 32'h0, {31'h0, wdt_r});
    src <= 5'h00;
    @(posedge hclk);
    chk("core off", 32'h0, {24'h0, seen});
    rchk("status off", xie_pkg::ADDR_STATUS, 32'h0);
    // with the enable on the time-out reaches the core
    bus(xie_pkg::ADDR_ENABLE, 1'b1, 32'h10);
    src <= 5'h04;
    @(posedge hclk);
    chk("wdt on", 32'h1, {31'h0, wdt_r});
    src <= 5'h00;
    @(posedge hclk);
    chk("core on", 32'h10, {24'h0, seen});
    rchk("status on", xie_pkg::ADDR_STATUS, 32'h10);
    // masked irq, then unmasked, then cleared
    chk("irq masked", 32'h0, {31'h0, irq});
    bus(xie_pkg::ADDR_MASK, 1'b1, 32'h10);
    @(posedge hclk);
    chk("irq on", 32'h1, {31'h0, irq});
    bus(xie_pkg::ADDR_STATUS, 1'b1, 32'h10);
    @(posedge hclk);
    chk("irq clr", 32'h0, {31'h0, irq});
    // unmapped place: write ignored, reads zero
    bus(32'h0000_0100, 1'b1, 32'hff);
    rchk("unmapped", 32'h0000_0100, 32'h0);
    rchk("enable kept", xie_pkg::ADDR_ENABLE, 32'h10);
    end_sim();
  end
endmodule
